/* File: icc_config_space.sv */
// Indexed chip configuration space: host index/data port and embedded processor port
// Operation
// - Per-device banks at 30h-FFh, chosen by 07h
// - Host port works only in configuration mode
// - Power-on reset restores all defaults
// - Block never raises an interrupt
// - Globals always reachable; host reaches banks only when selected
// - 48 global bytes, up to 208 per device
// - Undefined writes complete, change nothing
// - Undefined reads return FFh
// - Reserved globals ignore writes, read zero
// - Writing 07h selects current logical device
// - Host activate acts only on selected device; processor activate acts on the device it names
// - 20h returns fixed identification code
// - 21h returns silicon revision
// - Processor sees globals at same offsets
// - Processor reaches every bank directly
// - Host port decodes devices 1, 6, 7 only
// - Processor sees globals as device 3Fh
`timescale 1ns/1ps
module icc_config_space
    import icc_pkg::*;
#(
    // Arbitrary identification and revision values
    parameter icc_pkg::icc_byte_type CHIP_ID = 8'h5a,
    parameter icc_pkg::icc_byte_type CHIP_REV = 8'h01
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic config_mode,
    input wire logic host_index_wr,
    input wire logic host_data_wr,
    input wire logic host_data_rd,
    input wire icc_pkg::icc_byte_type host_wdata,
    output logic [icc_pkg::DATA_W-1:0] host_rdata,
    output logic [icc_pkg::DATA_W-1:0] host_index,
    input wire logic ec_wr,
    input wire logic ec_rd,
    input wire icc_pkg::icc_byte_type ec_ldn,
    input wire icc_pkg::icc_byte_type ec_offset,
    input wire icc_pkg::icc_byte_type ec_wdata,
    output logic [icc_pkg::DATA_W-1:0] ec_rdata,
    output logic [icc_pkg::DATA_W-1:0] selected_ldn,
    output logic [icc_pkg::NUM_BANKS-1:0] device_active,
    output logic irq
);
    import icc_pkg::*;

    typedef enum logic [1:0] {
        BK_NONE = 2'h0,
        BK_HIT = 2'h1
    } icc_hit_type;

    // Banks only for devices the host port decodes; others live elsewhere
    icc_byte_type bank_reg [NUM_BANKS][BANK_DEPTH];
    icc_byte_type bank_next [NUM_BANKS][BANK_DEPTH];
    icc_byte_type vendor_reg [OFF_GLOBAL_HI - OFF_VENDOR_LO + 8'h01];
    icc_byte_type vendor_next [OFF_GLOBAL_HI - OFF_VENDOR_LO + 8'h01];
    icc_byte_type ldn_reg, ldn_next;
    icc_byte_type index_reg, index_next;
    icc_byte_type host_rdata_reg, host_rdata_next;
    icc_byte_type ec_rdata_reg, ec_rdata_next;
    logic [NUM_BANKS-1:0] active_reg, active_next;
    logic irq_reg, irq_next;

    // Map a logical device number to its bank; only decoded devices hit
    function automatic logic bank_of(input icc_byte_type ldn, output logic [1:0] idx);
        bank_of = 1'b1;
        idx = BANK_IDX_KBC;
        unique case (ldn)
            LDN_KBC_EMUL: idx = BANK_IDX_KBC;
            LDN_PORT92: idx = BANK_IDX_P92;
            LDN_SERIAL: idx = BANK_IDX_SER;
            default: bank_of = 1'b0;
        endcase
    endfunction

    function automatic logic is_reserved_zero(input icc_byte_type off);
        is_reserved_zero = (off <= OFF_RSV_A_HI) || (off >= OFF_RSV_B_LO && off <= OFF_RSV_B_HI) ||
            (off == OFF_RSV_C);
    endfunction

    // Global read value; undefined global holes return FFh
    function automatic icc_byte_type global_read(input icc_byte_type off, input icc_byte_type ldn,
            input icc_byte_type vend);
        if (off == OFF_LDN) begin
            global_read = ldn;
        end else if (off == OFF_CHIP_ID) begin
            global_read = CHIP_ID;
        end else if (off == OFF_CHIP_REV) begin
            global_read = CHIP_REV;
        end else if (is_reserved_zero(off)) begin
            global_read = READ_ZERO;
        end else if (off >= OFF_VENDOR_LO && off <= OFF_GLOBAL_HI) begin
            global_read = vend;
        end else begin
            global_read = READ_UNDEF;
        end
    endfunction

    logic host_bank_ok, ec_bank_ok, ec_is_global;
    logic [1:0] host_bank_idx, ec_bank_idx;
    icc_byte_type host_boff, ec_boff, host_voff, ec_voff;

    always_comb begin
        host_bank_ok = bank_of(ldn_reg, host_bank_idx);
        ec_bank_ok = bank_of(ec_ldn, ec_bank_idx);
        ec_is_global = (ec_ldn == LDN_GLOBAL_EC) && (ec_offset <= OFF_GLOBAL_HI);
        host_boff = index_reg - OFF_BANK_LO;
        ec_boff = ec_offset - OFF_BANK_LO;
        host_voff = index_reg - OFF_VENDOR_LO;
        ec_voff = ec_offset - OFF_VENDOR_LO;
    end

    always_comb begin
        index_next = index_reg;
        ldn_next = ldn_reg;
        bank_next = bank_reg;
        vendor_next = vendor_reg;
        active_next = active_reg;
        host_rdata_next = host_rdata_reg;
        ec_rdata_next = ec_rdata_reg;
        // No interrupt source exists, so the request never rises
        irq_next = 1'b0;
        // Host port is dead outside configuration mode
        if (config_mode) begin
            if (host_index_wr) begin
                index_next = host_wdata;
            end
            if (host_data_wr) begin
                if (index_reg == OFF_LDN) begin
                    ldn_next = host_wdata;
                end else if (index_reg >= OFF_VENDOR_LO && index_reg <= OFF_GLOBAL_HI) begin
                    vendor_next[host_voff[3:0]] = host_wdata;
                end else if (index_reg >= OFF_BANK_LO && host_bank_ok) begin
                    bank_next[host_bank_idx][host_boff] = host_wdata;
                    if (index_reg == ACTIVATE_OFF) begin
                        active_next[host_bank_idx] = host_wdata[0];
                    end
                end
                // Anything else is dropped silently
            end
            if (host_data_rd) begin
                if (index_reg <= OFF_GLOBAL_HI) begin
                    host_rdata_next = global_read(index_reg, ldn_reg, vendor_reg[host_voff[3:0]]);
                end else if (host_bank_ok) begin
                    host_rdata_next = bank_reg[host_bank_idx][host_boff];
                end else begin
                    host_rdata_next = READ_UNDEF;
                end
            end
        end
        // Processor writes take effect after host writes in the same cycle
        if (ec_wr) begin
            if (ec_is_global) begin
                if (ec_offset == OFF_LDN) begin
                    ldn_next = ec_wdata;
                end else if (ec_offset >= OFF_VENDOR_LO) begin
                    vendor_next[ec_voff[3:0]] = ec_wdata;
                end
            end else if (ec_offset >= OFF_BANK_LO && ec_bank_ok) begin
                bank_next[ec_bank_idx][ec_boff] = ec_wdata;
                if (ec_offset == ACTIVATE_OFF) begin
                    active_next[ec_bank_idx] = ec_wdata[0];
                end
            end
        end
        if (ec_rd) begin
            if (ec_is_global) begin
                ec_rdata_next = global_read(ec_offset, ldn_reg, vendor_reg[ec_voff[3:0]]);
            end else if (ec_offset >= OFF_BANK_LO && ec_bank_ok) begin
                ec_rdata_next = bank_reg[ec_bank_idx][ec_boff];
            end else begin
                ec_rdata_next = READ_UNDEF;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            index_reg <= INDEX_RESET;
            ldn_reg <= LDN_RESET;
            host_rdata_reg <= READ_ZERO;
            ec_rdata_reg <= READ_ZERO;
            active_reg <= '0;
            irq_reg <= 1'b0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                for (int i = 0; i < BANK_DEPTH; i++) begin
                    bank_reg[b][i] <= READ_ZERO;
                end
            end
            for (int v = 0; v <= int'(OFF_GLOBAL_HI - OFF_VENDOR_LO); v++) begin
                vendor_reg[v] <= VENDOR_RESET;
            end
        end else begin
            index_reg <= index_next;
            ldn_reg <= ldn_next;
            host_rdata_reg <= host_rdata_next;
            ec_rdata_reg <= ec_rdata_next;
            active_reg <= active_next;
            irq_reg <= irq_next;
            bank_reg <= bank_next;
            vendor_reg <= vendor_next;
        end
    end

    always_comb begin
        host_rdata = host_rdata_reg;
        host_index = index_reg;
        ec_rdata = ec_rdata_reg;
        selected_ldn = ldn_reg;
        device_active = active_reg;
        irq = irq_reg;
    end
endmodule

/* File: icc_config_space_asserts.sv */
// Port-level checks for the configuration space
`timescale 1ns/1ps
module icc_config_space_asserts
    import icc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic config_mode,
    input wire logic host_index_wr,
    input wire logic host_data_wr,
    input wire logic host_data_rd,
    input wire logic ec_wr,
    input wire logic ec_rd,
    input wire logic irq,
    input wire icc_byte_type host_wdata,
    input wire icc_byte_type host_rdata,
    input wire icc_byte_type host_index,
    input wire icc_byte_type selected_ldn,
    input wire icc_byte_type ec_ldn,
    input wire icc_byte_type ec_offset,
    input wire icc_byte_type ec_wdata,
    input wire icc_byte_type ec_rdata,
    input wire logic [2:0] device_active
);
    logic hw, hr;
    // Same-cycle processor writes win, so host write checks stand aside then
    assign hw = config_mode && host_data_wr && !ec_wr;
    assign hr = config_mode && host_data_rd;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_NO_IRQ: assert property (irq == 1'b0) else $error("irq high");
    AST_RST_CLEAR: assert property (disable iff (1'b0) !resetn |=> selected_ldn == LDN_RESET && device_active == 3'h0)
        else $error("reset state");
    AST_INDEX_LOAD: assert property (config_mode && host_index_wr |=> host_index == $past(host_wdata))
        else $error("index load");
    AST_INDEX_HOLD: assert property (!(config_mode && host_index_wr) |=> $stable(host_index)) else $error("index");
    AST_SELECT: assert property (hw && host_index == OFF_LDN |=> selected_ldn == $past(host_wdata))
        else $error("select");
    AST_RSV_READ: assert property (hr && host_index inside {[OFF_RSV_B_LO:OFF_RSV_B_HI]} |=> host_rdata == READ_ZERO)
        else $error("rsv read");
    AST_RSV_WRITE: assert property (hw && host_index inside {[OFF_RSV_B_LO:OFF_RSV_B_HI]} |=>
        $stable(selected_ldn) && $stable(device_active)) else $error("rsv write");
    AST_UNDEF_READ: assert property (hr && host_index == 8'h22 |=> host_rdata == READ_UNDEF) else $error("undef");
    AST_NO_BANK: assert property (hr && selected_ldn == 8'h03 && host_index == ACTIVATE_OFF |=> host_rdata == READ_UNDEF)
        else $error("bank");
    cover property (hw && host_index == OFF_LDN);
    cover property (hw && host_index == ACTIVATE_OFF);
    cover property (ec_rd && ec_ldn == LDN_GLOBAL_EC);
endmodule

/* File: icc_host_model.sv */
// Host controller model driving the index and data ports
`timescale 1ns/1ps
module icc_host_model
    import icc_pkg::*;
(
    input wire logic clock,
    output logic host_index_wr, host_data_wr, host_data_rd,
    output icc_pkg::icc_byte_type host_wdata
);
    initial {host_index_wr, host_data_wr, host_data_rd, host_wdata} = 11'h0;
    // Op 0 loads index, 1 writes data, 2 reads; callers open mode first, select via 07h, leave 25h-2Fh alone
    task automatic acc(input int op, input icc_byte_type d);
        @(posedge clock);
        #1;
        {host_index_wr, host_data_wr, host_data_rd} = {op == 0, op == 1, op == 2};
        host_wdata = d;
        @(posedge clock);
        #1;
        {host_index_wr, host_data_wr, host_data_rd} = 3'h0;
        host_wdata = ~d; // A released bus must not keep showing the last byte
    endtask
endmodule

/* File: icc_pkg.sv */
// Constants and types for the indexed chip configuration space
package icc_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int LDN_W = 8;
    localparam logic [7:0] OFF_LDN = 8'h07;
    localparam logic [7:0] OFF_CHIP_ID = 8'h20;
    localparam logic [7:0] OFF_CHIP_REV = 8'h21;
    localparam logic [7:0] OFF_RSV_A_LO = 8'h00;
    localparam logic [7:0] OFF_RSV_A_HI = 8'h06;
    localparam logic [7:0] OFF_RSV_B_LO = 8'h08;
    localparam logic [7:0] OFF_RSV_B_HI = 8'h1f;
    localparam logic [7:0] OFF_RSV_C = 8'h24;
    localparam logic [7:0] OFF_VENDOR_LO = 8'h25;
    localparam logic [7:0] OFF_GLOBAL_HI = 8'h2f;
    localparam logic [7:0] OFF_BANK_LO = 8'h30;
    localparam int NUM_GLOBAL = 48;
    localparam int BANK_DEPTH = 208;
    localparam logic [7:0] LDN_KBC_EMUL = 8'h01;
    localparam logic [7:0] LDN_PORT92 = 8'h06;
    localparam logic [7:0] LDN_SERIAL = 8'h07;
    localparam logic [7:0] LDN_GLOBAL_EC = 8'h3f;
    localparam logic [7:0] READ_UNDEF = 8'hff;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] LDN_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] VENDOR_RESET = 8'h00;
    localparam logic [1:0] BANK_IDX_KBC = 2'h0;
    localparam logic [1:0] BANK_IDX_P92 = 2'h1;
    localparam logic [1:0] BANK_IDX_SER = 2'h2;
    localparam int NUM_BANKS = 3;
    localparam logic [7:0] ACTIVATE_OFF = 8'h30;
    typedef logic [7:0] icc_byte_type;
endpackage

/* File: tb.sv */
// Self-checking bench for the configuration space
`timescale 1ns/1ps
module tb;
    import icc_pkg::*;
    localparam icc_byte_type ID = 8'h5a; // Arbitrary identification value
    localparam icc_byte_type LDNS [3] = '{LDN_KBC_EMUL, LDN_PORT92, LDN_SERIAL};
    logic clock = 0, resetn = 0, config_mode = 0, ec_wr = 0, ec_rd = 0;
    logic host_index_wr, host_data_wr, host_data_rd, irq;
    icc_byte_type host_wdata, host_rdata, host_index, selected_ldn, ec_rdata, d;
    icc_byte_type ec_ldn = 0, ec_offset = 0, ec_wdata = 0;
    logic [2:0] device_active, ref_act = 3'h0;
    int n_errors = 0, compares = 0;
    initial forever #50 clock = ~clock;
    icc_host_model i_host(.*);
    icc_config_space #(.CHIP_ID(ID)) i_dut(.*);
    task automatic chk(input icc_byte_type seen, input icc_byte_type exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Index then data; a read compares the returned byte with v
    task automatic hx(input icc_byte_type off, input int op, input icc_byte_type v);
        i_host.acc(0, off);
        i_host.acc(op, v);
        if (op == 2) chk(host_rdata, v);
    endtask
    task automatic ecx(input logic w, input icc_byte_type l, o, v);
        @(posedge clock);
        #1;
        {ec_wr, ec_rd, ec_ldn, ec_offset, ec_wdata} = {w, !w, l, o, v};
        @(posedge clock);
        #1;
        {ec_wr, ec_rd, ec_wdata} = {2'h0, ~v};
    endtask
    initial begin
        void'($urandom(32'h5729));
        repeat (10) @(posedge clock);
        #1;
        resetn = 1;
        config_mode = 1;
        hx(OFF_CHIP_ID, 2, ID);
        hx(OFF_CHIP_REV, 2, 8'h01);
        hx(8'h22, 2, READ_UNDEF);
        foreach (LDNS[i]) begin
            hx(OFF_LDN, 1, LDNS[i]);
            chk(selected_ldn, LDNS[i]);
            hx(ACTIVATE_OFF, 1, 8'h01);
            ref_act[i] = 1'b1;
            chk({5'h0, device_active}, {5'h0, ref_act});
            hx(ACTIVATE_OFF, 2, 8'h01);
        end
        repeat (3) begin
            d = 8'($urandom_range(31, 8));
            hx(d, 1, 8'($urandom));
            hx(d, 2, READ_ZERO);
        end
        config_mode = 0;
        hx(OFF_LDN, 1, LDN_KBC_EMUL);
        config_mode = 1;
        chk(selected_ldn, LDN_SERIAL);
        hx(OFF_LDN, 1, 8'h03);
        hx(ACTIVATE_OFF, 2, READ_UNDEF);
        ecx(0, LDN_GLOBAL_EC, OFF_CHIP_ID, 8'h00);
        chk(ec_rdata, ID);
        ecx(1, LDN_PORT92, ACTIVATE_OFF, 8'h00);
        chk({5'h0, device_active}, 8'h05);
        chk({7'h0, irq}, 8'h00);
        resetn = 0;
        repeat (2) @(posedge clock);
        #1;
        resetn = 1;
        chk({5'h0, device_active}, 8'h00);
        give_verdict();
    end
    // Tests need about a hundred cycles; two thousand means a hang
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
endmodule
bind icc_config_space icc_config_space_asserts i_chk(.*);
